// [hw/rfl_pkg.sv]
// shared constants and types of the raster fill and line engine
package rfl_pkg;

	localparam int ADDR_W     = 24;
	localparam int CNT_W      = 16;
	localparam int STIP_IDX_W = 5;
	localparam int PAT_IDX_W  = 4;
	localparam int BCOL_IDX_W = 3;
	localparam int MODE_W     = 4;
	localparam int ROP_W      = 4;
	localparam int IDX_HI     = 4;
	localparam int IDX_LO     = 2;

	// apb byte offsets
	localparam logic [7:0] OFF_MODE   = 8'h00;
	localparam logic [7:0] OFF_ROP    = 8'h04;
	localparam logic [7:0] OFF_CFG    = 8'h08;
	localparam logic [7:0] OFF_FG     = 8'h0c;
	localparam logic [7:0] OFF_BG     = 8'h10;
	localparam logic [7:0] OFF_PADDR  = 8'h14;
	localparam logic [7:0] OFF_PDATA  = 8'h18;
	localparam logic [7:0] OFF_BRES1  = 8'h1c;
	localparam logic [7:0] OFF_BRES2  = 8'h20;
	localparam logic [7:0] OFF_BRES3  = 8'h24;
	localparam logic [7:0] OFF_CONT   = 8'h28;
	localparam logic [7:0] OFF_WIDTH  = 8'h2c;
	localparam logic [7:0] OFF_CSRC   = 8'h30;
	localparam logic [7:0] OFF_STAT   = 8'h34;
	localparam logic [7:0] OFF_FBWR   = 8'h38;
	localparam logic [7:0] OFF_SLOPE  = 8'h40;
	localparam logic [7:0] OFF_BCOL   = 8'h60;
	localparam logic [7:0] RANGE_MASK = 8'he0;

	// field positions
	localparam int CFG_PACKED  = 0;
	localparam int CFG_CLOG_LO = 4;
	localparam int CFG_CLOG_HI = 6;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_REFUSED = 1;
	localparam int OCT_XNEG = 0;
	localparam int OCT_YNEG = 1;
	localparam int OCT_YMAJ = 2;

	// reset values and limits
	localparam logic [31:0]      PDATA_RST = 32'h0000ffff;
	localparam logic [15:0]      WIDTH_RST = 16'h0400;
	localparam logic [ROP_W-1:0] ROP_COPY  = 4'h3;
	localparam logic [CNT_W-1:0] MAX_FILL  = 16'h0800;
	localparam logic [CNT_W-1:0] STIP_SPAN = 16'h0020;
	localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0]      STEP_ONE  = 16'h0001;

	typedef enum logic [MODE_W-1:0] {
		MODE_SIMPLE   = 4'h0,
		MODE_OPQ_STIP = 4'h1,
		MODE_TRN_STIP = 4'h2,
		MODE_OPQ_LINE = 4'h3,
		MODE_TRN_LINE = 4'h4,
		MODE_OPQ_FILL = 4'h5,
		MODE_TRN_FILL = 4'h6,
		MODE_COPY     = 4'h7,
		MODE_DMA_RD   = 4'h8,
		MODE_BLK_STIP = 4'h9,
		MODE_BLK_FILL = 4'ha
	} rfl_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_RUN   = 2'b11,
		ST_WAIT  = 2'b10
	} rfl_state_t;

endpackage

// [hw/rfl_bcol_mem.sv]
// eight-entry block-colour pattern memory with registered read
`timescale 1ns/1ns
module rfl_bcol_mem
	import rfl_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// write side
	input  wire logic                  we,
	input  wire logic [BCOL_IDX_W-1:0] waddr,
	input  wire logic [31:0]           wdata,
	// read side
	input  wire logic [BCOL_IDX_W-1:0] raddr,
	output logic      [31:0]           rdata
);
	logic [31:0] mem [0:(1<<BCOL_IDX_W)-1];

	always_ff @(posedge mclk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end
endmodule

// [hw/rfl_line_setup.sv]
// derives bresenham terms from octant and absolute deltas
`timescale 1ns/1ns
module rfl_line_setup
	import rfl_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// request
	input  wire logic        start,
	input  wire logic [2:0]  octant,
	input  wire logic [15:0] dx,
	input  wire logic [15:0] dy,
	input  wire logic [15:0] width,
	// terms, valid one cycle after start
	output logic      [15:0] a1,
	output logic      [15:0] a2,
	output logic      [15:0] inc1,
	output logic      [15:0] inc2,
	output logic      [15:0] e0,
	output logic      [15:0] len
);
	logic [15:0] xs;
	logic [15:0] ys;
	logic [15:0] major;
	logic [15:0] minor;
	logic [15:0] majStep;
	logic [15:0] minStep;

	always_comb
	begin
		xs = octant[OCT_XNEG] ? 16'(-STEP_ONE) : STEP_ONE;
		ys = octant[OCT_YNEG] ? 16'(-width) : width;
		major = octant[OCT_YMAJ] ? dy : dx;
		minor = octant[OCT_YMAJ] ? dx : dy;
		majStep = octant[OCT_YMAJ] ? ys : xs;
		minStep = octant[OCT_YMAJ] ? xs : ys;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			a1 <= '0;
			a2 <= '0;
			inc1 <= '0;
			inc2 <= '0;
			e0 <= '0;
			len <= '0;
		end
		else if (start)
		begin
			a1 <= majStep;
			a2 <= 16'(majStep + minStep);
			inc1 <= 16'(minor << 1);
			inc2 <= 16'((minor - major) << 1);
			e0 <= 16'((minor << 1) - major);
			len <= major;
		end
	end
endmodule

// [hw/rfl_engine.sv]
// raster fill and line engine: apb registers, span fill and line stepping
`timescale 1ns/1ns
// Notes on behaviour
// - Block fill is refused unless the raster op is plain copy and the target is not packed.
// - The block-fill mask is the 32-pixel repeating pattern data register.
// - Block modes colour pixels from the eight pre-rotated block-colour entries.
// - A block-fill write covers up to 2K pixels, a block-stipple write 32.
// - One frame-buffer write completes a whole span in a block mode.
// - Block stipple takes a per-pixel mask from each write, covering 32 pixels.
// - Opaque and transparent fills use any raster op, fg/bg colours, 32-pixel pattern.
// - Copy modes repeat a source pattern from local or host memory.
// - With loaded Bresenham terms a frame-buffer write starts the line.
// - A slope register write derives the terms and starts the line at once.
// - A continue write extends the current line by the given pixel count.
// - The low 16 pattern-data bits gate line pixels, upper bits ignored.
// - Any loaded pattern styles the line instead of all ones.
// - A new line without an address write starts one pixel past the last one.
// - Line pixels use foreground for set bits; opaque lines use background for clear bits, transparent lines skip them.
module rfl_engine
	import rfl_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// pixel write port
	output logic                   pixWe,
	output logic      [ADDR_W-1:0] pixAddr,
	output logic      [31:0]       pixData,
	// pixel read port for copies
	output logic                   pixRdReq,
	output logic                   pixRdHost,
	output logic      [ADDR_W-1:0] pixRdAddr,
	input  wire logic [31:0]       pixRdData,
	input  wire logic              pixRdValid
);
	rfl_state_t        stateReg;
	rfl_mode_t         modeReg;
	logic [ROP_W-1:0]  ropReg;
	logic              packedReg;
	logic [2:0]        copyLogReg;
	logic [31:0]       fgReg;
	logic [31:0]       bgReg;
	logic [31:0]       pdataReg;
	logic [31:0]       srcReg;
	logic [15:0]       widthReg;
	logic [ADDR_W-1:0] curAddrReg;
	logic [15:0]       a1Reg;
	logic [15:0]       a2Reg;
	logic [15:0]       inc1Reg;
	logic [15:0]       inc2Reg;
	logic [15:0]       e0Reg;
	logic [15:0]       lenReg;
	logic [15:0]       errReg;
	logic [31:0]       maskReg;
	logic [CNT_W-1:0]  cntReg;
	logic [CNT_W-1:0]  idxReg;
	logic [PAT_IDX_W-1:0] patIdxReg;
	logic              slopeReg;
	logic              refusedReg;
	logic              preadyReg;
	logic              pslverrReg;
	logic [31:0]       prdataReg;
	logic              pixWeReg;
	logic [ADDR_W-1:0] pixAddrReg;
	logic [31:0]       pixDataReg;
	logic              pixRdReqReg;
	logic              pixRdHostReg;
	logic [ADDR_W-1:0] pixRdAddrReg;

	logic              wrDone;
	logic              accessFirst;
	logic              isSlope;
	logic              isBcol;
	logic              mapped;
	logic              busy;
	logic              goFb;
	logic              goCont;
	logic              goSlope;
	logic [31:0]       rdMux;
	logic              lineMode;
	logic              blkMode;
	logic              stipMode;
	logic              fillMode;
	logic              copyMode;
	logic              opaqueCls;
	logic              blkOk;
	logic              bitSel;
	logic              drawEn;
	logic [31:0]       color;
	logic              errNeg;
	logic [15:0]       stepInc;
	logic [ADDR_W-1:0] nextAddr;
	logic [15:0]       nextErr;
	logic [CNT_W-1:0]  copyMask;
	logic [CNT_W-1:0]  spanLen;
	logic [31:0]       bcolRd;
	logic [15:0]       suA1;
	logic [15:0]       suA2;
	logic [15:0]       suInc1;
	logic [15:0]       suInc2;
	logic [15:0]       suE0;
	logic [15:0]       suLen;

	// apb decode; every write except status stalls while a draw runs
	assign isSlope = (paddr & RANGE_MASK) == OFF_SLOPE;
	assign isBcol = (paddr & RANGE_MASK) == OFF_BCOL;
	assign mapped = ~|paddr[1:0] && (paddr <= OFF_FBWR || isSlope || isBcol);
	assign busy = stateReg != ST_IDLE;
	assign accessFirst = psel & penable & ~preadyReg;
	assign wrDone = psel & penable & preadyReg & pwrite;
	assign goFb = wrDone && paddr == OFF_FBWR;
	assign goCont = wrDone && paddr == OFF_CONT && lineMode;
	assign goSlope = wrDone && isSlope && lineMode;

	// mode classes
	assign lineMode = modeReg == MODE_OPQ_LINE || modeReg == MODE_TRN_LINE;
	assign blkMode = modeReg == MODE_BLK_STIP || modeReg == MODE_BLK_FILL;
	assign stipMode = modeReg == MODE_OPQ_STIP || modeReg == MODE_TRN_STIP
		|| modeReg == MODE_BLK_STIP;
	assign fillMode = modeReg == MODE_OPQ_FILL || modeReg == MODE_TRN_FILL
		|| modeReg == MODE_BLK_FILL;
	assign copyMode = modeReg == MODE_COPY || modeReg == MODE_DMA_RD;
	assign opaqueCls = modeReg == MODE_OPQ_LINE || modeReg == MODE_OPQ_FILL
		|| modeReg == MODE_OPQ_STIP || modeReg == MODE_SIMPLE;
	assign blkOk = ropReg == ROP_COPY && !packedReg;

	always_comb
	begin
		rdMux = '0;
		case (paddr)
			OFF_MODE:  rdMux = 32'(modeReg);
			OFF_ROP:   rdMux = 32'(ropReg);
			OFF_CFG:
			begin
				rdMux[CFG_PACKED] = packedReg;
				rdMux[CFG_CLOG_HI:CFG_CLOG_LO] = copyLogReg;
			end
			OFF_FG:    rdMux = fgReg;
			OFF_BG:    rdMux = bgReg;
			OFF_PADDR: rdMux = 32'(curAddrReg);
			OFF_PDATA: rdMux = pdataReg;
			OFF_BRES1: rdMux = {inc1Reg, a1Reg};
			OFF_BRES2: rdMux = {inc2Reg, a2Reg};
			OFF_BRES3: rdMux = {e0Reg, lenReg};
			OFF_CONT:  rdMux = 32'(cntReg);
			OFF_WIDTH: rdMux = 32'(widthReg);
			OFF_CSRC:  rdMux = srcReg;
			OFF_STAT:
			begin
				rdMux[STAT_BUSY] = busy;
				rdMux[STAT_REFUSED] = refusedReg;
			end
			default:   rdMux = '0;
		endcase
	end

	// two-cycle access, writes other than status stretched while the engine is busy
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
			prdataReg <= '0;
		end
		else
		begin
			preadyReg <= accessFirst & ~(pwrite & busy & paddr != OFF_STAT);
			if (accessFirst)
			begin
				pslverrReg <= ~mapped;
				prdataReg <= (mapped & ~pwrite) ? rdMux : '0;
			end
		end
	end

	// software configuration
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			modeReg <= MODE_SIMPLE;
			ropReg <= ROP_COPY;
			packedReg <= 1'b0;
			copyLogReg <= '0;
			fgReg <= '0;
			bgReg <= '0;
			pdataReg <= PDATA_RST;
			widthReg <= WIDTH_RST;
			srcReg <= '0;
		end
		else if (wrDone)
		begin
			case (paddr)
				OFF_MODE:  modeReg <= rfl_mode_t'(pwdata[MODE_W-1:0]);
				OFF_ROP:   ropReg <= pwdata[ROP_W-1:0];
				OFF_CFG:
				begin
					packedReg <= pwdata[CFG_PACKED];
					copyLogReg <= pwdata[CFG_CLOG_HI:CFG_CLOG_LO];
				end
				OFF_FG:    fgReg <= pwdata;
				OFF_BG:    bgReg <= pwdata;
				OFF_PDATA: pdataReg <= pwdata;
				OFF_WIDTH: widthReg <= pwdata[15:0];
				OFF_CSRC:  srcReg <= pwdata;
				default:   ;
			endcase
		end
	end

	// pixel decision for the current step
	always_comb
	begin
		if (lineMode)
			bitSel = pdataReg[patIdxReg];
		else if (stipMode)
			bitSel = maskReg[idxReg[STIP_IDX_W-1:0]];
		else
			bitSel = pdataReg[curAddrReg[STIP_IDX_W-1:0]];
		drawEn = bitSel | opaqueCls;
		if (blkMode)
			color = bcolRd;
		else if (modeReg == MODE_SIMPLE)
			color = maskReg;
		else
			color = bitSel ? fgReg : bgReg;
		errNeg = errReg[15];
		stepInc = lineMode ? (errNeg ? a1Reg : a2Reg) : STEP_ONE;
		nextAddr = curAddrReg + ADDR_W'(signed'(stepInc));
		nextErr = errReg + (errNeg ? inc1Reg : inc2Reg);
		copyMask = CNT_W'((CNT_ONE << copyLogReg) - CNT_ONE);
		if (stipMode)
			spanLen = STIP_SPAN;
		else if (fillMode)
			spanLen = pwdata[CNT_W-1:0] > MAX_FILL ? MAX_FILL : pwdata[CNT_W-1:0];
		else if (copyMode)
			spanLen = pwdata[CNT_W-1:0];
		else
			spanLen = CNT_ONE;
	end

	// drawing engine
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			stateReg <= ST_IDLE;
			curAddrReg <= '0;
			a1Reg <= '0;
			a2Reg <= '0;
			inc1Reg <= '0;
			inc2Reg <= '0;
			e0Reg <= '0;
			lenReg <= '0;
			errReg <= '0;
			maskReg <= '0;
			cntReg <= '0;
			idxReg <= '0;
			patIdxReg <= '0;
			slopeReg <= 1'b0;
			refusedReg <= 1'b0;
			pixWeReg <= 1'b0;
			pixAddrReg <= '0;
			pixDataReg <= '0;
			pixRdReqReg <= 1'b0;
			pixRdHostReg <= 1'b0;
			pixRdAddrReg <= '0;
		end
		else
		begin
			pixWeReg <= 1'b0;
			pixRdReqReg <= 1'b0;
			if (wrDone && paddr == OFF_STAT && pwdata[STAT_REFUSED])
				refusedReg <= 1'b0;
			case (stateReg)
				ST_IDLE:
				begin
					// address writes park here; lines otherwise chain on
					if (wrDone && paddr == OFF_PADDR)
						curAddrReg <= pwdata[ADDR_W-1:0];
					if (wrDone && paddr == OFF_BRES1)
						{inc1Reg, a1Reg} <= pwdata;
					if (wrDone && paddr == OFF_BRES2)
						{inc2Reg, a2Reg} <= pwdata;
					if (wrDone && paddr == OFF_BRES3)
						{e0Reg, lenReg} <= pwdata;
					if (goSlope)
					begin
						slopeReg <= 1'b1;
						patIdxReg <= '0;
						stateReg <= ST_SETUP;
					end
					else if (goCont)
					begin
						slopeReg <= 1'b0;
						cntReg <= pwdata[CNT_W-1:0];
						stateReg <= ST_SETUP;
					end
					else if (goFb)
					begin
						slopeReg <= 1'b0;
						idxReg <= '0;
						maskReg <= pwdata;
						if (lineMode)
						begin
							errReg <= e0Reg;
							cntReg <= lenReg;
							patIdxReg <= '0;
							stateReg <= ST_SETUP;
						end
						else if (blkMode && !blkOk)
							refusedReg <= 1'b1;
						else
						begin
							cntReg <= spanLen;
							stateReg <= ST_SETUP;
						end
					end
				end
				ST_SETUP:
				begin
					// one cycle lets setup terms and the first colour read settle
					if (slopeReg)
					begin
						a1Reg <= suA1;
						a2Reg <= suA2;
						inc1Reg <= suInc1;
						inc2Reg <= suInc2;
						e0Reg <= suE0;
						lenReg <= suLen;
						errReg <= suE0;
						cntReg <= suLen;
					end
					stateReg <= ST_RUN;
				end
				ST_RUN:
				begin
					if (cntReg == '0)
						stateReg <= ST_IDLE;
					else if (copyMode)
					begin
						pixRdReqReg <= 1'b1;
						pixRdHostReg <= modeReg == MODE_DMA_RD;
						pixRdAddrReg <= srcReg[ADDR_W-1:0] + ADDR_W'(idxReg & copyMask);
						stateReg <= ST_WAIT;
					end
					else
					begin
						pixWeReg <= drawEn;
						pixAddrReg <= curAddrReg;
						pixDataReg <= color;
						curAddrReg <= nextAddr;
						if (lineMode)
							errReg <= nextErr;
						patIdxReg <= patIdxReg + 1'b1;
						idxReg <= idxReg + CNT_ONE;
						cntReg <= cntReg - CNT_ONE;
						if (cntReg == CNT_ONE)
							stateReg <= ST_IDLE;
					end
				end
				ST_WAIT:
				begin
					if (pixRdValid)
					begin
						pixWeReg <= 1'b1;
						pixAddrReg <= curAddrReg;
						pixDataReg <= pixRdData;
						curAddrReg <= nextAddr;
						idxReg <= idxReg + CNT_ONE;
						cntReg <= cntReg - CNT_ONE;
						stateReg <= cntReg == CNT_ONE ? ST_IDLE : ST_RUN;
					end
				end
				default: stateReg <= ST_IDLE;
			endcase
		end
	end

	rfl_line_setup u_setup (
		.mclk   (mclk),
		.rst    (rst),
		.start  (goSlope),
		.octant (paddr[IDX_HI:IDX_LO]),
		.dx     (pwdata[15:0]),
		.dy     (pwdata[31:16]),
		.width  (widthReg),
		.a1     (suA1),
		.a2     (suA2),
		.inc1   (suInc1),
		.inc2   (suInc2),
		.e0     (suE0),
		.len    (suLen)
	);

	// reads one pixel ahead so block colour meets its pixel
	rfl_bcol_mem u_bcol (
		.mclk  (mclk),
		.rst   (rst),
		.we    (wrDone && isBcol),
		.waddr (paddr[IDX_HI:IDX_LO]),
		.wdata (pwdata),
		.raddr (stateReg == ST_RUN ? nextAddr[BCOL_IDX_W-1:0] : curAddrReg[BCOL_IDX_W-1:0]),
		.rdata (bcolRd)
	);

	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign pixWe = pixWeReg;
	assign pixAddr = pixAddrReg;
	assign pixData = pixDataReg;
	assign pixRdReq = pixRdReqReg;
	assign pixRdHost = pixRdHostReg;
	assign pixRdAddr = pixRdAddrReg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_lineStart;
		stateReg == ST_SETUP ##1 stateReg == ST_RUN;
	endsequence

	property p_refuse;
		goFb && blkMode && !blkOk |=> refusedReg && stateReg == ST_IDLE;
	endproperty
	a_refuse: assert property (p_refuse) else $error("block write not refused");

	property p_span_max;
		stateReg == ST_RUN && modeReg == MODE_BLK_FILL |-> cntReg <= MAX_FILL;
	endproperty
	a_span_max: assert property (p_span_max) else $error("fill span too long");

	property p_stip_span;
		goFb && modeReg == MODE_BLK_STIP && blkOk |=> cntReg == STIP_SPAN;
	endproperty
	a_stip_span: assert property (p_stip_span) else $error("stipple span not 32");

	property p_fb_line;
		goFb && lineMode |=> s_lineStart;
	endproperty
	a_fb_line: assert property (p_fb_line) else $error("line did not start");

	property p_slope_go;
		goSlope |=> s_lineStart;
	endproperty
	a_slope_go: assert property (p_slope_go) else $error("slope write idle");

	property p_cont;
		goCont |=> ($stable(errReg) && stateReg == ST_SETUP) ##1 stateReg == ST_RUN;
	endproperty
	a_cont: assert property (p_cont) else $error("continue broke line");

	property p_trn_skip;
		stateReg == ST_RUN && cntReg != '0 && modeReg == MODE_TRN_LINE
			&& !pdataReg[patIdxReg] |=> !pixWeReg;
	endproperty
	a_trn_skip: assert property (p_trn_skip) else $error("masked pixel drawn");

	property p_opq_bg;
		stateReg == ST_RUN && cntReg != '0 && modeReg == MODE_OPQ_LINE
			&& !pdataReg[patIdxReg] |=> pixWeReg && pixDataReg == $past(bgReg);
	endproperty
	a_opq_bg: assert property (p_opq_bg) else $error("clear bit not background");

	property p_connect;
		goFb && lineMode && lenReg != '0 |-> ##3 pixAddrReg == $past(curAddrReg, 3);
	endproperty
	a_connect: assert property (p_connect) else $error("line start address wrong");
endmodule

// [verif/rfl_pix_mem.sv]
// pixel memory model: logs pixel writes, answers source reads at varying latency
`timescale 1ns/1ns
module rfl_pix_mem
	import rfl_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// pixel writes
	input  wire logic              pixWe,
	input  wire logic [ADDR_W-1:0] pixAddr,
	input  wire logic [31:0]       pixData,
	// source reads
	input  wire logic              pixRdReq,
	input  wire logic              pixRdHost,
	input  wire logic [ADDR_W-1:0] pixRdAddr,
	output logic      [31:0]       pixRdData,
	output logic                   pixRdValid
);
	logic [ADDR_W-1:0] wa[$];
	logic [31:0]       wd[$];
	logic [ADDR_W-1:0] ra[$];
	logic              rh[$];
	logic [ADDR_W-1:0] srcA;
	logic [1:0]        waitCnt;
	logic              slow;

	always @(posedge mclk)
	begin
		if (pixWe)
		begin
			wa.push_back(pixAddr);
			wd.push_back(pixData);
		end
		if (pixRdReq)
		begin
			ra.push_back(pixRdAddr);
			rh.push_back(pixRdHost);
		end
	end

	// alternate quick and slow answers; data is scrambled outside the valid cycle
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			waitCnt <= 2'd0;
			slow <= 1'b0;
			srcA <= '0;
			pixRdValid <= 1'b0;
			pixRdData <= 32'h0;
		end
		else
		begin
			pixRdValid <= 1'b0;
			if (pixRdValid)
				pixRdData <= ~pixRdData;
			if (pixRdReq)
			begin
				waitCnt <= slow ? 2'd3 : 2'd1;
				slow <= ~slow;
				srcA <= pixRdAddr;
			end
			else if (waitCnt == 2'd1)
			begin
				pixRdValid <= 1'b1;
				pixRdData <= {8'h5a, srcA};
				waitCnt <= 2'd0;
			end
			else if (waitCnt != 2'd0)
				waitCnt <= waitCnt - 2'd1;
		end
	end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the raster fill and line engine
`timescale 1ns/1ns
module tb_top
	import rfl_pkg::*;
;
	logic              mclk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic              pixWe, pixRdReq, pixRdHost, pixRdValid;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, pixData, pixRdData, rd;
	logic [ADDR_W-1:0] pixAddr, pixRdAddr;
	int                num_errors, total_checks, n0;

	rfl_engine dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pixWe, .pixAddr, .pixData, .pixRdReq, .pixRdHost, .pixRdAddr, .pixRdData,
		.pixRdValid);
	rfl_pix_mem mem_u (.mclk, .rst, .pixWe, .pixAddr, .pixData, .pixRdReq, .pixRdHost,
		.pixRdAddr, .pixRdData, .pixRdValid);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// entered just after a rising edge; leaves one edge after the answer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 300 && pready !== 1'b1; k++)
			@(posedge mclk);
		if (k == 300)
		begin
			num_errors++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic draw(input logic [7:0] a, input logic [31:0] d);
		int k;
		n0 = mem_u.wa.size();
		apb(1'b1, a, d);
		for (k = 0; k < 3000; k++)
		begin
			apb(1'b0, OFF_STAT, 32'h0);
			if (rd[STAT_BUSY] === 1'b0)
				break;
		end
		if (k == 3000)
		begin
			num_errors++;
			complete_run();
		end
	endtask

	task automatic cnt(input int n);
		check("pixCount", 32'(mem_u.wa.size() - n0), 32'(n));
	endtask

	task automatic pix(input int i, input logic [23:0] ea, input logic [31:0] ed);
		check("pixAddr", 32'(mem_u.wa[n0 + i]), 32'(ea));
		check("pixData", mem_u.wd[n0 + i], ed);
	endtask

	task automatic t_reset;
		logic [7:0]  a[5] = '{OFF_MODE, OFF_ROP, OFF_PDATA, OFF_WIDTH, 8'h3c};
		logic [31:0] e[5] = '{32'h0, 32'h3, PDATA_RST, 32'h400, 32'h0};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, a[i], 32'h0);
			check("regRead", rd, e[i]);
			check("slvErr", {31'h0, err}, {31'h0, 1'(i == 4)});
		end
		$display("reset test done");
	endtask

	task automatic t_block;
		for (int i = 0; i < 8; i++)
			apb(1'b1, OFF_BCOL + 8'(4 * i), 32'ha5a50000 + 32'(i));
		apb(1'b1, OFF_MODE, 32'ha);
		apb(1'b1, OFF_PDATA, 32'hffffff7f);
		apb(1'b1, OFF_PADDR, 32'h6);
		draw(OFF_FBWR, 32'h4);
		cnt(3);
		pix(0, 24'h6, 32'ha5a50006);
		pix(1, 24'h8, 32'ha5a50000);
		pix(2, 24'h9, 32'ha5a50001);
		apb(1'b1, OFF_PDATA, 32'hffffffff);
		apb(1'b1, OFF_PADDR, 32'h0);
		draw(OFF_FBWR, 32'h1000);
		cnt(2048);
		check("lastAddr", 32'(mem_u.wa[$]), 32'h7ff);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, OFF_ROP, i == 0 ? 32'h5 : 32'h3);
			apb(1'b1, OFF_CFG, 32'(i));
			draw(OFF_FBWR, 32'h4);
			cnt(0);
			check("refused", {31'h0, rd[STAT_REFUSED]}, 32'h1);
			apb(1'b1, OFF_STAT, 32'h2);
		end
		apb(1'b1, OFF_CFG, 32'h0);
		apb(1'b1, OFF_MODE, 32'h9);
		apb(1'b1, OFF_PADDR, 32'h40);
		draw(OFF_FBWR, 32'h80000005);
		cnt(3);
		pix(1, 24'h42, 32'ha5a50002);
		pix(2, 24'h5f, 32'ha5a50007);
		$display("block test done");
	endtask

	task automatic t_line;
		apb(1'b1, OFF_MODE, 32'h3);
		apb(1'b1, OFF_FG, 32'hf0f0f0f0);
		apb(1'b1, OFF_BG, 32'h0b0b0b0b);
		apb(1'b1, OFF_PADDR, 32'h100);
		apb(1'b1, OFF_PDATA, 32'habcd0005);
		draw(OFF_SLOPE, 32'h4);
		cnt(4);
		pix(0, 24'h100, 32'hf0f0f0f0);
		pix(1, 24'h101, 32'h0b0b0b0b);
		pix(3, 24'h103, 32'h0b0b0b0b);
		draw(OFF_SLOPE, 32'h2);
		check("joinAddr", 32'(mem_u.wa[n0]), 32'h104);
		draw(OFF_CONT, 32'h3);
		cnt(3);
		check("contAddr", 32'(mem_u.wa[n0 + 2]), 32'h108);
		apb(1'b1, OFF_MODE, 32'h4);
		apb(1'b1, OFF_PADDR, 32'h200);
		apb(1'b1, OFF_PDATA, 32'h9);
		draw(OFF_SLOPE, 32'h4);
		cnt(2);
		pix(1, 24'h203, 32'hf0f0f0f0);
		apb(1'b1, OFF_MODE, 32'h3);
		apb(1'b1, OFF_PDATA, 32'hffff);
		apb(1'b1, OFF_PADDR, 32'h300);
		apb(1'b1, OFF_BRES1, 32'h1);
		apb(1'b1, OFF_BRES2, 32'h1);
		apb(1'b1, OFF_BRES3, 32'h3);
		draw(OFF_FBWR, 32'h0);
		cnt(3);
		pix(2, 24'h302, 32'hf0f0f0f0);
		$display("line test done");
	endtask

	// nontrivial rop must still draw; pattern bits 0 and 2 pick the pixels
	task automatic t_fill;
		apb(1'b1, OFF_ROP, 32'h5);
		apb(1'b1, OFF_PDATA, 32'h5);
		apb(1'b1, OFF_MODE, 32'h6);
		apb(1'b1, OFF_PADDR, 32'h600);
		draw(OFF_FBWR, 32'h3);
		cnt(2);
		pix(1, 24'h602, 32'hf0f0f0f0);
		apb(1'b1, OFF_MODE, 32'h5);
		apb(1'b1, OFF_PADDR, 32'h600);
		draw(OFF_FBWR, 32'h3);
		cnt(3);
		pix(1, 24'h601, 32'h0b0b0b0b);
		$display("fill test done");
	endtask

	task automatic t_copy;
		int n1;
		for (int m = 7; m < 9; m++)
		begin
			apb(1'b1, OFF_MODE, 32'(m));
			apb(1'b1, OFF_CSRC, 32'h400);
			apb(1'b1, OFF_CFG, 32'h10);
			apb(1'b1, OFF_PADDR, 32'h500);
			n1 = mem_u.ra.size();
			draw(OFF_FBWR, 32'h2);
			cnt(2);
			check("srcHost", {31'h0, mem_u.rh[n1]}, 32'(m == 8));
			check("srcAddr", 32'(mem_u.ra[n1]), 32'h400);
			pix(1, 24'h501, 32'h5a000401);
		end
		$display("copy test done");
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		num_errors = 0;
		total_checks = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_block();
		t_line();
		t_fill();
		t_copy();
		complete_run();
	end
endmodule
